// File: pkg/ipc_regs.svh
// Register offsets, field positions, reset values and timing counts of the interrupt priority block
`ifndef IPC_REGS_SVH
`define IPC_REGS_SVH
`define IPC_OFF_PRIO5      12'h000
`define IPC_OFF_PRIO11     12'h004
`define IPC_OFF_FLAGS      12'h008
`define IPC_OFF_ENABLES    12'h00C
`define IPC_OFF_CTRL1      12'h010
`define IPC_OFF_CPU        12'h014
`define IPC_OFF_ACK        12'h018
`define IPC_OFF_EVSTAT     12'h01C
`define IPC_OFF_EVMASK     12'h020
`define IPC_PRIO_RESET     3'h4
`define IPC_PRIO5_MASK     16'h0707
`define IPC_PRIO11_MASK    16'h0077
`define IPC_NEST_BIT       15
`define IPC_LVL_MAX_USER   4'h7
`define IPC_SRL_BLOCK      8'hE0
`define IPC_TIMED_IRQ_DISABLE_INSTR_CYCLES    16'h0010
`define IPC_NSRC           5
`endif

// File: pkg/ipc_pkg.sv
// Types shared by the interrupt priority block
package ipc_pkg;
    typedef struct packed {
        logic        valid;
        logic [3:0]  level;
        logic [2:0]  vector;
    } ipc_req_t;
    typedef struct packed {
        logic [7:0]  status_low_byte;
        logic [23:0] pc;
    } ipc_frame_t;
    typedef enum logic [1:0] {IPC_IDLE, IPC_SERVICE} ipc_state_t;
endpackage

// File: design/ipc_ctrl.sv
// Interrupt priority controller with AHB-Lite register slave
`timescale 1ns/10ps
`include "ipc_regs.svh"
// Contract
// - Code 111 is level 7, 000 disables source
// - Every priority field resets to level 4
// - Unimplemented priority bits read zero, ignore writes
// - Fifth register: ext irq1 field bits 2..0
// - Fifth register: capture7 field bits 10..8
// - Eleventh register: compare8 low, parallel port above
// - Nesting disable bit blocks preemption while servicing
// - Source requests only when enabled and flagged
// - Flag left set retriggers interrupt after return
// - Trap flag left set retriggers trap after return
// - Return restores pc, status low byte, old level
// - CPU level 7 via E0h blocks user interrupts
// - Traps levels 8..15 are never masked; here a trap is held until no interrupt is in service
// - Timed disable blocks levels 1..6 only
module ipc_ctrl
    import ipc_pkg::*;
#(
    parameter int TIMED_IRQ_DISABLE_INSTR_CYCLES = `IPC_TIMED_IRQ_DISABLE_INSTR_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [11:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic [4:0]  src_event_i,
    input  wire logic        trap_event_i,
    input  wire logic        timed_irq_disable_instr_start_i,
    input  wire logic        return_from_irq_instr_i,
    input  wire logic [23:0] cur_pc_i,
    output logic             irq_take_o,
    output logic      [2:0]  irq_vector_o,
    output logic      [3:0]  cpu_level_o,
    output logic      [23:0] ret_pc_o,
    output logic             ret_valid_o,
    output logic             irq_o
);
    // Refuse a timed disable length the 16-bit counter cannot hold
    if (TIMED_IRQ_DISABLE_INSTR_CYCLES < 1 || TIMED_IRQ_DISABLE_INSTR_CYCLES > 65535) begin : g_bad_timed_irq_disable_instr
        $error("TIMED_IRQ_DISABLE_INSTR_CYCLES out of range");
    end

    logic [15:0] prio5_reg;
    logic [15:0] prio11_reg;
    logic [4:0]  flags_reg;
    logic [4:0]  enables_reg;
    logic        nest_reg;
    logic        trap_flag_reg;
    logic [7:0]  srl_reg;
    logic [15:0] timed_irq_disable_instr_cnt_reg;
    logic [2:0]  evstat_reg;
    logic [2:0]  evmask_reg;
    ipc_state_t  state_reg;
    ipc_frame_t  frame_reg;
    logic        wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic        rd_pend_reg;
    logic [11:0] rd_addr_reg;

    // Source field extraction
    function automatic logic [2:0] src_prio(input logic [15:0] p5, input logic [15:0] p11, input int idx);
        logic [2:0] r;
        r = 3'h0;
        case (idx)
            0:       r = p5[2:0];
            1:       r = p5[10:8];
            2:       r = p11[2:0];
            3:       r = p11[6:4];
            default: r = p5[2:0];
        endcase
        return r;
    endfunction

    // Priority per source, fifth source shares ext irq1 field
    logic [2:0] prio [0:4];
    assign prio[0] = src_prio(prio5_reg, prio11_reg, 0);
    assign prio[1] = src_prio(prio5_reg, prio11_reg, 1);
    assign prio[2] = src_prio(prio5_reg, prio11_reg, 2);
    assign prio[3] = src_prio(prio5_reg, prio11_reg, 3);
    assign prio[4] = src_prio(prio5_reg, prio11_reg, 4);

    // Arbitration: highest level, lowest vector on ties
    ipc_req_t best;
    always_comb begin
        best = '0;
        for (int i = 0; i < `IPC_NSRC; i++) begin
            if (flags_reg[i] && enables_reg[i] && prio[i] != 3'h0 &&
                (!best.valid || {1'b0, prio[i]} > best.level)) begin
                best.valid  = 1'b1;
                best.level  = {1'b0, prio[i]};
                best.vector = 3'(i);
            end
        end
    end

    // Masking by CPU level and timed disable
    wire [3:0] cpu_lvl    = {1'b0, srl_reg[7:5]};
    wire       timed_irq_disable_instr_act   = timed_irq_disable_instr_cnt_reg != 16'h0000;
    wire       above_cpu  = best.level > cpu_lvl;
    wire       timed_irq_disable_instr_ok    = !timed_irq_disable_instr_act || best.level == `IPC_LVL_MAX_USER;
    wire       nest_ok    = !(nest_reg && state_reg == IPC_SERVICE);
    wire       user_take  = best.valid && above_cpu && timed_irq_disable_instr_ok && nest_ok;
    wire       trap_take  = trap_flag_reg && state_reg == IPC_IDLE;
    wire       take       = trap_take || (!trap_flag_reg && user_take);

    // Register hit during a pending data phase
    function automatic logic reg_hit(input logic pend, input logic [11:0] addr, input logic [11:0] off);
        return pend && addr == off;
    endfunction

    // Bus decode
    wire       bus_go     = hsel_i && hready_i && htrans_i[1];
    wire       rd_ack     = reg_hit(rd_pend_reg, rd_addr_reg, `IPC_OFF_ACK);
    wire       rd_stat    = reg_hit(rd_pend_reg, rd_addr_reg, `IPC_OFF_EVSTAT);
    wire [31:0] wdat      = hwdata_i;
    wire       w_p5       = reg_hit(wr_pend_reg, wr_addr_reg, `IPC_OFF_PRIO5);
    wire       w_p11      = reg_hit(wr_pend_reg, wr_addr_reg, `IPC_OFF_PRIO11);
    wire       w_flg      = reg_hit(wr_pend_reg, wr_addr_reg, `IPC_OFF_FLAGS);
    wire       w_en       = reg_hit(wr_pend_reg, wr_addr_reg, `IPC_OFF_ENABLES);
    wire       w_c1       = reg_hit(wr_pend_reg, wr_addr_reg, `IPC_OFF_CTRL1);
    wire       w_cpu      = reg_hit(wr_pend_reg, wr_addr_reg, `IPC_OFF_CPU);
    wire       w_msk      = reg_hit(wr_pend_reg, wr_addr_reg, `IPC_OFF_EVMASK);
    wire [2:0] ev_now     = {return_from_irq_instr_i, trap_event_i, take};

    // Read mux
    logic [31:0] rdata;
    always_comb begin
        case (haddr_i)
            `IPC_OFF_PRIO5:   rdata = {16'h0000, prio5_reg};
            `IPC_OFF_PRIO11:  rdata = {16'h0000, prio11_reg};
            `IPC_OFF_FLAGS:   rdata = {27'h0000000, flags_reg};
            `IPC_OFF_ENABLES: rdata = {27'h0000000, enables_reg};
            `IPC_OFF_CTRL1:   rdata = {16'h0000, nest_reg, 14'h0000, trap_flag_reg};
            `IPC_OFF_CPU:     rdata = {timed_irq_disable_instr_cnt_reg, 8'h00, srl_reg};
            `IPC_OFF_EVSTAT:  rdata = {29'h00000000, evstat_reg};
            `IPC_OFF_EVMASK:  rdata = {29'h00000000, evmask_reg};
            default:          rdata = 32'h00000000;
        endcase
    end

    // Bus phase tracking and outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            rd_addr_reg <= 12'h000;
            hrdata_o    <= 32'h00000000;
        end else begin
            wr_pend_reg <= bus_go && hwrite_i;
            rd_pend_reg <= bus_go && !hwrite_i;
            wr_addr_reg <= haddr_i;
            rd_addr_reg <= haddr_i;
            if (bus_go && !hwrite_i) hrdata_o <= rdata;
        end
    end
    always_ff @(posedge clk_i) begin
        hreadyout_o <= 1'b1;
        hresp_o     <= 1'b0;
    end

    // Priority registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prio5_reg  <= {5'h00, `IPC_PRIO_RESET, 5'h00, `IPC_PRIO_RESET};
            prio11_reg <= {9'h000, `IPC_PRIO_RESET, 1'b0, `IPC_PRIO_RESET};
        end else begin
            if (w_p5)  prio5_reg  <= wdat[15:0] & `IPC_PRIO5_MASK;
            if (w_p11) prio11_reg <= wdat[15:0] & `IPC_PRIO11_MASK;
        end
    end

    // Flags, enables, control; hardware set beats software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg     <= 5'h00;
            enables_reg   <= 5'h00;
            nest_reg      <= 1'b0;
            trap_flag_reg <= 1'b0;
        end else begin
            flags_reg     <= (w_flg ? wdat[4:0] : flags_reg) | src_event_i;
            if (w_en) enables_reg <= wdat[4:0];
            if (w_c1) nest_reg <= wdat[`IPC_NEST_BIT];
            trap_flag_reg <= (w_c1 ? wdat[0] : trap_flag_reg) | trap_event_i;
        end
    end

    // Service state, CPU level, stack frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg    <= IPC_IDLE;
            srl_reg      <= 8'h00;
            frame_reg    <= '0;
            irq_take_o   <= 1'b0;
            irq_vector_o <= 3'h0;
            ret_valid_o  <= 1'b0;
            ret_pc_o     <= 24'h000000;
        end else begin
            irq_take_o  <= 1'b0;
            ret_valid_o <= 1'b0;
            case (state_reg)
                IPC_IDLE, IPC_SERVICE: begin
                    if (return_from_irq_instr_i && state_reg == IPC_SERVICE) begin
                        srl_reg     <= frame_reg.status_low_byte;
                        ret_pc_o    <= frame_reg.pc;
                        ret_valid_o <= 1'b1;
                        state_reg   <= IPC_IDLE;
                    end else if (take) begin
                        frame_reg    <= '{status_low_byte: srl_reg, pc: cur_pc_i};
                        srl_reg      <= {trap_take ? 3'h7 : best.level[2:0], srl_reg[4:0]};
                        irq_take_o   <= 1'b1;
                        irq_vector_o <= trap_take ? 3'h7 : best.vector;
                        state_reg    <= IPC_SERVICE;
                    end else if (w_cpu) begin
                        srl_reg <= wdat[7:0];
                    end
                end
                default: state_reg <= IPC_IDLE;
            endcase
        end
    end

    // Level seen by the core, registered; trap service lifts bit 3
    wire [3:0] level_now = {trap_flag_reg && state_reg == IPC_SERVICE, srl_reg[7:5]};
    always_ff @(posedge clk_i) begin
        if (rst_i) cpu_level_o <= 4'h0;
        else cpu_level_o <= level_now;
    end

    // Timed disable counter
    always_ff @(posedge clk_i) begin
        if (rst_i) timed_irq_disable_instr_cnt_reg <= 16'h0000;
        else if (timed_irq_disable_instr_start_i) timed_irq_disable_instr_cnt_reg <= 16'(TIMED_IRQ_DISABLE_INSTR_CYCLES);
        else if (timed_irq_disable_instr_act) timed_irq_disable_instr_cnt_reg <= timed_irq_disable_instr_cnt_reg - 16'h0001;
    end

    // Event status, cleared by read, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evstat_reg <= 3'h0;
            evmask_reg <= 3'h0;
            irq_o      <= 1'b0;
        end else begin
            evstat_reg <= (rd_stat ? 3'h0 : evstat_reg) | ev_now;
            if (w_msk) evmask_reg <= wdat[2:0];
            irq_o      <= |(evstat_reg & evmask_reg);
        end
    end

    wire unused_ok = rd_ack ^ hsize_i[0];

    // Checks
    property p_level7_blocks;
        @(posedge clk_i) disable iff (rst_i)
        (srl_reg[7:5] == 3'h7 && !trap_flag_reg) |=> !irq_take_o;
    endproperty
    a_level7_blocks: assert property (p_level7_blocks) else $error("take while level 7");
    property p_reset_prio;
        @(posedge clk_i) $fell(rst_i) |-> prio5_reg == 16'h0404;
    endproperty
    a_reset_prio: assert property (p_reset_prio) else $error("prio reset wrong");
    property p_unimpl_zero;
        @(posedge clk_i) disable iff (rst_i)
        (prio5_reg & ~`IPC_PRIO5_MASK) == 16'h0000 && (prio11_reg & ~`IPC_PRIO11_MASK) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");
    property p_nest;
        @(posedge clk_i) disable iff (rst_i)
        (nest_reg && state_reg == IPC_SERVICE && !return_from_irq_instr_i) |=> !irq_take_o;
    endproperty
    a_nest: assert property (p_nest) else $error("nested despite disable");
    property p_trap;
        @(posedge clk_i) disable iff (rst_i)
        (trap_flag_reg && state_reg == IPC_IDLE) |=> irq_take_o && irq_vector_o == 3'h7;
    endproperty
    a_trap: assert property (p_trap) else $error("trap not taken");
    property p_timed_irq_disable_instr;
        @(posedge clk_i) disable iff (rst_i)
        (timed_irq_disable_instr_act && !trap_flag_reg && best.level < 4'h7) |=> !irq_take_o;
    endproperty
    a_timed_irq_disable_instr: assert property (p_timed_irq_disable_instr) else $error("timed disable leaked");
    property p_ret;
        @(posedge clk_i) disable iff (rst_i)
        (return_from_irq_instr_i && state_reg == IPC_SERVICE) |=> ret_valid_o && ret_pc_o == $past(frame_reg.pc);
    endproperty
    a_ret: assert property (p_ret) else $error("return restore wrong");
    property p_enable;
        @(posedge clk_i) disable iff (rst_i)
        (irq_take_o && irq_vector_o != 3'h7) |-> (($past(enables_reg) >> irq_vector_o) & 5'h01) == 5'h01;
    endproperty
    a_enable: assert property (p_enable) else $error("disabled source taken");
    // Return restores the saved status low byte
    property p_ret_srl;
        @(posedge clk_i) disable iff (rst_i)
        (return_from_irq_instr_i && state_reg == IPC_SERVICE) |=> srl_reg == $past(frame_reg.status_low_byte);
    endproperty
    a_ret_srl: assert property (p_ret_srl) else $error("status byte not restored");
    // Return pulse lasts one cycle
    property p_ret_pulse;
        @(posedge clk_i) disable iff (rst_i)
        ret_valid_o |=> !ret_valid_o;
    endproperty
    a_ret_pulse: assert property (p_ret_pulse) else $error("return pulse too long");
    // Timed disable loads its full length
    property p_timed_irq_disable_instr_load;
        @(posedge clk_i) disable iff (rst_i)
        timed_irq_disable_instr_start_i |=> timed_irq_disable_instr_cnt_reg == 16'(TIMED_IRQ_DISABLE_INSTR_CYCLES);
    endproperty
    a_timed_irq_disable_instr_load: assert property (p_timed_irq_disable_instr_load) else $error("timed disable not loaded");
    // Source events always land in their flags
    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        (|src_event_i) |=> (flags_reg & $past(src_event_i)) == $past(src_event_i);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("source flag lost");
    // Trap events always land in the trap flag
    property p_trap_set;
        @(posedge clk_i) disable iff (rst_i)
        trap_event_i |=> trap_flag_reg;
    endproperty
    a_trap_set: assert property (p_trap_set) else $error("trap flag lost");
    // A user take always raises the CPU level
    property p_take_above;
        @(posedge clk_i) disable iff (rst_i)
        (irq_take_o && irq_vector_o != 3'h7) |-> srl_reg[7:5] > $past(srl_reg[7:5]);
    endproperty
    a_take_above: assert property (p_take_above) else $error("take not above level");
    // Bus never stalls and always answers okay
    property p_ready_okay;
        @(posedge clk_i) disable iff (rst_i)
        hreadyout_o && !hresp_o;
    endproperty
    a_ready_okay: assert property (p_ready_okay) else $error("bus stall or error");
    // Interrupt line follows masked status
    property p_irq_follow;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> irq_o == $past(|(evstat_reg & evmask_reg));
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("interrupt line wrong");
endmodule // ipc_ctrl

// File: tb/ipc_core_model.sv
// Processor core stand-in: fetch address and return pulses
`timescale 1ns/10ps
module ipc_core_model (
    input  wire logic        clk_i,
    input  wire logic        ret_req_i,
    output logic      [23:0] cur_pc_o,
    output logic             return_from_irq_instr_o
);
    // Address moves only on a return, so a take sees a stable value
    initial cur_pc_o = 24'h000100;
    initial return_from_irq_instr_o = 1'b0;
    always @(posedge clk_i) begin
        return_from_irq_instr_o <= ret_req_i;
        if (return_from_irq_instr_o) begin
            cur_pc_o <= cur_pc_o + 24'h000010;
        end
    end
endmodule // ipc_core_model

// File: tb/ipc_ctrl_test.sv
// Self-checking bench for the interrupt priority controller
`timescale 1ns/10ps
`include "ipc_regs.svh"
module ipc_ctrl_test;
    logic        clk, rst, hsel, hwrite, hready, ret_req, trap, timed_irq_disable_instr, take, ret_valid, irq, return_from_irq_instr, resp;
    logic [1:0]  htrans;
    logic [11:0] haddr;
    logic [31:0] hwdata, hrdata;
    logic [4:0]  src;
    logic [2:0]  vec;
    logic [3:0]  level;
    logic [23:0] cur_pc, ret_pc, pc_exp;
    int          err_count, checks;

    ipc_ctrl #(.TIMED_IRQ_DISABLE_INSTR_CYCLES(8)) i_ipc_ctrl (
        .clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(resp), .src_event_i(src),
        .trap_event_i(trap), .timed_irq_disable_instr_start_i(timed_irq_disable_instr), .return_from_irq_instr_i(return_from_irq_instr), .cur_pc_i(cur_pc),
        .irq_take_o(take), .irq_vector_o(vec), .cpu_level_o(level), .ret_pc_o(ret_pc),
        .ret_valid_o(ret_valid), .irq_o(irq));

    ipc_core_model i_ipc_core_model (.clk_i(clk), .ret_req_i(ret_req), .cur_pc_o(cur_pc), .return_from_irq_instr_o(return_from_irq_instr));

    // Clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // One AHB-Lite single word transfer
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask

    task automatic ev(input logic [4:0] s, input logic t, input logic d);
        src  <= s;
        trap <= t;
        timed_irq_disable_instr <= d;
        @(posedge clk);
        src  <= 5'h00;
        trap <= 1'b0;
        timed_irq_disable_instr <= 1'b0;
    endtask

    task automatic quiet(input int n, input string s);
        logic seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if (take === 1'b1) seen = 1'b1;
        end
        chk(s, 32'h0, {31'h0, seen});
    endtask

    // Waits for a take and checks its vector
    task automatic tk(input logic [2:0] v, input string n);
        int i;
        for (i = 0; i < 40 && take !== 1'b1; i++) @(posedge clk);
        chk(n, {28'h0, 1'b1, v}, {28'h0, take, vec});
        pc_exp = cur_pc;
    endtask

    task automatic ret(input string n);
        int i;
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        for (i = 0; i < 20 && ret_valid !== 1'b1; i++) @(posedge clk);
        chk(n, {8'h01, pc_exp}, {7'h00, ret_valid, ret_pc});
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #(3000 * 100);
        err_count++;
        tally_and_finish();
    end

    // Test sequence
    initial begin
        {rst, hsel, hwrite, ret_req, trap, timed_irq_disable_instr, src, htrans, haddr, hwdata} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`IPC_OFF_PRIO5, 32'h0000_0404, "prio5 reset");
        rd(`IPC_OFF_PRIO11, 32'h0000_0044, "prio11 reset");
        wr(`IPC_OFF_PRIO5, 32'hFFFF_FFFF);
        rd(`IPC_OFF_PRIO5, 32'h0000_0707, "prio5 unused bits");
        wr(`IPC_OFF_PRIO11, 32'hFFFF_FFFF);
        rd(`IPC_OFF_PRIO11, 32'h0000_0077, "prio11 unused bits");
        rd(12'h0FC, 32'h0, "unmapped");
        $display("test registers done");
        wr(`IPC_OFF_PRIO5, 32'h0000_0502);
        wr(`IPC_OFF_PRIO11, 32'h0000_0035);
        wr(`IPC_OFF_EVMASK, 32'h1);
        ev(5'h06, 1'b0, 1'b0);
        quiet(20, "not enabled");
        wr(`IPC_OFF_ENABLES, 32'h1F);
        tk(3'h1, "tie vector");
        @(posedge clk);
        chk("level", 32'h5, {28'h0, level});
        ret("return one");
        tk(3'h1, "retake");
        wr(`IPC_OFF_FLAGS, 32'h0);
        ret("return two");
        quiet(20, "flags cleared");
        chk("level restored", 32'h0, {28'h0, level});
        wr(`IPC_OFF_PRIO5, 32'h0000_0500);
        ev(5'h01, 1'b0, 1'b0);
        quiet(20, "code zero");
        $display("test take done");
        wr(`IPC_OFF_PRIO11, 32'h0000_0007);
        wr(`IPC_OFF_CTRL1, 32'h0000_8000);
        ev(5'h02, 1'b0, 1'b0);
        tk(3'h1, "first");
        ev(5'h04, 1'b0, 1'b0);
        quiet(20, "no nesting");
        wr(`IPC_OFF_FLAGS, 32'h4);
        ret("nest return");
        tk(3'h2, "after return");
        @(posedge clk);
        chk("level seven", 32'h7, {28'h0, level});
        wr(`IPC_OFF_FLAGS, 32'h0);
        ret("return three");
        wr(`IPC_OFF_CTRL1, 32'h0);
        $display("test nesting done");
        wr(`IPC_OFF_CPU, 32'hE0);
        ev(5'h04, 1'b0, 1'b0);
        quiet(20, "cpu level 7");
        ev(5'h00, 1'b1, 1'b0);
        tk(3'h7, "trap");
        @(posedge clk);
        chk("trap level", 32'h1, {31'h0, level[3]});
        wr(`IPC_OFF_CTRL1, 32'h0);
        ret("trap return");
        quiet(10, "trap cleared");
        wr(`IPC_OFF_CPU, 32'h0);
        tk(3'h2, "level restored take");
        wr(`IPC_OFF_FLAGS, 32'h0);
        ret("return four");
        $display("test masking done");
        ev(5'h02, 1'b0, 1'b1);
        quiet(4, "timed disable");
        tk(3'h1, "after timed disable");
        wr(`IPC_OFF_FLAGS, 32'h0);
        ret("return five");
        $display("test timed disable done");
        wr(`IPC_OFF_EVMASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`IPC_OFF_EVMASK, 32'h7);
        repeat (2) @(posedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        rd(`IPC_OFF_EVSTAT, 32'h7, "event status");
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        chk("okay response", 32'h0, {31'h0, resp});
        $display("test interrupt done");
        tally_and_finish();
    end
endmodule // ipc_ctrl_test
